// ---- serdes_test_pkg.sv ----
// Constants shared by the serial-lane test status and error counting logic.
// Assumes a 32-bit register port with byte offsets on an 8-bit address.
package serdes_test_pkg;

  // Register port geometry.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets.
  localparam logic [ADDR_W-1:0] TEST_CTRL_OFFSET   = 8'hbc;
  localparam logic [ADDR_W-1:0] SYNC_STATUS_OFFSET = 8'hc4;
  localparam logic [ADDR_W-1:0] CNT_CFG_OFFSET     = 8'hc8;
  localparam logic [ADDR_W-1:0] CNT01_OFFSET       = 8'hcc;
  localparam logic [ADDR_W-1:0] IRQ_STATUS_OFFSET  = 8'he0;
  localparam logic [ADDR_W-1:0] IRQ_ENABLE_OFFSET  = 8'he4;
  localparam logic [ADDR_W-1:0] IRQ_CLEAR_OFFSET   = 8'he8;

  // Lane and port geometry.
  localparam int LANES     = 8;
  localparam int PORTS     = 3;
  localparam int ALL_LANES = LANES * PORTS;

  // Test control register fields.
  localparam int ENABLE_LSB     = 0;
  localparam int INVERT_BIT     = 24;
  localparam int TX_RESYNC_BIT  = 25;
  localparam int RX_RESYNC_BIT  = 26;
  localparam logic [DATA_W-1:0] TEST_CTRL_RESET = 32'h00ff_ffff;

  // Count configuration fields: counter k has its lane select at 5k, port select above it.
  localparam int LANE_SEL_W   = 3;
  localparam int PORT_SEL_W   = 2;
  localparam int SEL_STRIDE   = LANE_SEL_W + PORT_SEL_W;
  localparam int COUNTERS_ALL = 6;
  localparam int CFG_USED_W   = SEL_STRIDE * COUNTERS_ALL;
  localparam logic [CFG_USED_W-1:0] CNT_CFG_RESET = 30'h0000_0000;

  // Port select encodings.
  localparam logic [PORT_SEL_W-1:0] PORT_SEL_A = 2'h0;
  localparam logic [PORT_SEL_W-1:0] PORT_SEL_B = 2'h1;
  localparam logic [PORT_SEL_W-1:0] PORT_SEL_C = 2'h2;

  // Error counters.
  localparam int CNT_W    = 16;
  localparam int CNT1_LSB = 16;

  // Interrupt status bits.
  localparam int IRQ_W        = 3;
  localparam int IRQ_SYNC_BIT = 0;
  localparam int IRQ_SAT0_BIT = 1;
  localparam int IRQ_SAT1_BIT = 2;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;

endpackage

// ---- sat_clear_counter.sv ----
// Saturating event counter with an atomic clear-on-read.
// Assumes inc and clr come from logic on the same clock.
`timescale 1ns/1ps
module sat_clear_counter #(
  parameter int WIDTH = 16
) (
  // Clock and reset.
  input  wire logic             ref_clk,
  input  wire logic             rst,
  // Control.
  input  wire logic             inc,
  input  wire logic             clr,
  // State.
  output logic [WIDTH-1:0]      count_q,
  output logic                  sat_hit
);

  localparam logic [WIDTH-1:0] MAX_COUNT = {WIDTH{1'b1}};
  localparam logic [WIDTH-1:0] ONE       = {{(WIDTH-1){1'b0}}, 1'b1};

  logic [WIDTH-1:0] count_d;

  always_comb begin
    count_d = count_q;
    if (clr) begin
      count_d = inc ? ONE : '0;
    end else if (inc && count_q != MAX_COUNT) begin
      count_d = count_q + ONE;
    end
    sat_hit = (count_d == MAX_COUNT) && (count_q != MAX_COUNT);
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

endmodule

// ---- serdes_test_sync_error_count.sv ----
// Sync status flags and selectable lane error counters for serial-lane test mode.
// Assumes checker sync and error inputs and the mode inputs are on ref_clk.
`timescale 1ns/1ps
module serdes_test_sync_error_count #(
  parameter int LANES = serdes_test_pkg::LANES
) (
  // Clock and reset.
  input  wire logic                                ref_clk,
  input  wire logic                                rst,
  // Register port.
  input  wire logic [serdes_test_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [serdes_test_pkg::DATA_W-1:0]  reg_wr_data,
  input  wire logic                                reg_wr,
  input  wire logic                                reg_rd,
  output logic [serdes_test_pkg::DATA_W-1:0]       reg_rd_data,
  // Switch mode.
  input  wire logic                                test_mode_active,
  input  wire logic                                test_mode_sync_needed,
  // Pattern checkers.
  input  wire logic [3*LANES-1:0]                  lane_sync_done,
  input  wire logic [3*LANES-1:0]                  lane_error,
  // Lane control.
  output logic [3*LANES-1:0]                       lane_participate,
  output logic                                     tx_resync,
  output logic                                     rx_resync,
  output logic                                     invert_tx_stream,
  // Selectors for counters 2 to 5.
  output logic [19:0]                              extra_counter_select,
  // Interrupt.
  output logic                                     irq
);

  localparam int NL = 3 * LANES;
  localparam int DW = serdes_test_pkg::DATA_W;
  localparam int CW = serdes_test_pkg::CNT_W;
  localparam int SW = serdes_test_pkg::SEL_STRIDE;
  localparam int IW = serdes_test_pkg::IRQ_W;

  // Register state.
  logic [NL-1:0]                           enable_q;
  logic [NL-1:0]                           enable_d;
  logic                                    invert_q;
  logic                                    invert_d;
  logic [serdes_test_pkg::CFG_USED_W-1:0]  cfg_q;
  logic [serdes_test_pkg::CFG_USED_W-1:0]  cfg_d;
  logic [NL-1:0]                           sync_q;
  logic [NL-1:0]                           sync_d;
  logic [IW-1:0]                           irq_status_q;
  logic [IW-1:0]                           irq_status_d;
  logic [IW-1:0]                           irq_enable_q;
  logic [IW-1:0]                           irq_enable_d;
  logic [DW-1:0]                           rd_data_q;
  logic [DW-1:0]                           rd_data_d;
  logic [NL-1:0]                           participate_q;
  logic [NL-1:0]                           participate_d;
  logic                                    tx_resync_q;
  logic                                    tx_resync_d;
  logic                                    rx_resync_q;
  logic                                    rx_resync_d;

  // Decoded accesses.
  logic                                    wr_ctrl;
  logic                                    wr_sync;
  logic                                    wr_cfg;
  logic                                    wr_irq_en;
  logic                                    wr_irq_clr;
  logic                                    rd_counts;

  // Counter datapath.
  logic [CW-1:0]                           count0;
  logic [CW-1:0]                           count1;
  logic                                    inc0;
  logic                                    inc1;
  logic                                    sat0;
  logic                                    sat1;
  logic [NL-1:0]                           active_lanes;
  logic [NL-1:0]                           sync_set;

  // Picks the error of one lane of one port; the reserved port code picks none.
  function automatic logic pick_error(
    input logic [NL-1:0]                               errors,
    input logic [serdes_test_pkg::PORT_SEL_W-1:0]      port_sel,
    input logic [serdes_test_pkg::LANE_SEL_W-1:0]      lane_sel
  );
    logic hit;
    hit = 1'b0;
    case (port_sel)
      serdes_test_pkg::PORT_SEL_A: begin
        hit = errors[0*LANES + int'(lane_sel)];
      end
      serdes_test_pkg::PORT_SEL_B: begin
        hit = errors[1*LANES + int'(lane_sel)];
      end
      serdes_test_pkg::PORT_SEL_C: begin
        hit = errors[2*LANES + int'(lane_sel)];
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    return hit;
  endfunction

  // Address decode.
  always_comb begin
    wr_ctrl    = reg_wr && (reg_addr == serdes_test_pkg::TEST_CTRL_OFFSET);
    wr_sync    = reg_wr && (reg_addr == serdes_test_pkg::SYNC_STATUS_OFFSET);
    wr_cfg     = reg_wr && (reg_addr == serdes_test_pkg::CNT_CFG_OFFSET);
    wr_irq_en  = reg_wr && (reg_addr == serdes_test_pkg::IRQ_ENABLE_OFFSET);
    wr_irq_clr = reg_wr && (reg_addr == serdes_test_pkg::IRQ_CLEAR_OFFSET);
    rd_counts  = reg_rd && (reg_addr == serdes_test_pkg::CNT01_OFFSET);
  end

  // Test control register and lane participation.
  always_comb begin
    enable_d    = enable_q;
    invert_d    = invert_q;
    tx_resync_d = 1'b0;
    rx_resync_d = 1'b0;
    if (wr_ctrl) begin
      enable_d = reg_wr_data[serdes_test_pkg::ENABLE_LSB +: NL];
      invert_d = reg_wr_data[serdes_test_pkg::INVERT_BIT];
      tx_resync_d = reg_wr_data[serdes_test_pkg::TX_RESYNC_BIT]
                    && test_mode_active && test_mode_sync_needed;
      rx_resync_d = reg_wr_data[serdes_test_pkg::RX_RESYNC_BIT]
                    && test_mode_active && test_mode_sync_needed;
    end
    active_lanes  = test_mode_active ? enable_q : '0;
    participate_d = active_lanes;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      enable_q      <= serdes_test_pkg::TEST_CTRL_RESET[serdes_test_pkg::ENABLE_LSB +: NL];
      invert_q      <= serdes_test_pkg::TEST_CTRL_RESET[serdes_test_pkg::INVERT_BIT];
      tx_resync_q   <= 1'b0;
      rx_resync_q   <= 1'b0;
      participate_q <= '0;
    end else begin
      enable_q      <= enable_d;
      invert_q      <= invert_d;
      tx_resync_q   <= tx_resync_d;
      rx_resync_q   <= rx_resync_d;
      participate_q <= participate_d;
    end
  end

  // Sync achieved flags.
  always_comb begin
    sync_set = active_lanes & lane_sync_done;
    sync_d   = sync_q;
    if (wr_sync) begin
      sync_d = sync_d & ~reg_wr_data[NL-1:0];
    end
    sync_d = sync_d | sync_set;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sync_q <= '0;
    end else begin
      sync_q <= sync_d;
    end
  end

  // Count configuration register.
  always_comb begin
    cfg_d = cfg_q;
    if (wr_cfg) begin
      cfg_d = reg_wr_data[serdes_test_pkg::CFG_USED_W-1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cfg_q <= serdes_test_pkg::CNT_CFG_RESET;
    end else begin
      cfg_q <= cfg_d;
    end
  end

  // Error selection for counters 0 and 1.
  always_comb begin
    inc0 = pick_error(lane_error & active_lanes,
                      cfg_q[0*SW + serdes_test_pkg::LANE_SEL_W +: serdes_test_pkg::PORT_SEL_W],
                      cfg_q[0*SW +: serdes_test_pkg::LANE_SEL_W]);
    inc1 = pick_error(lane_error & active_lanes,
                      cfg_q[1*SW + serdes_test_pkg::LANE_SEL_W +: serdes_test_pkg::PORT_SEL_W],
                      cfg_q[1*SW +: serdes_test_pkg::LANE_SEL_W]);
  end

  sat_clear_counter #(
    .WIDTH   (CW)
  ) u_counter0 (
    .ref_clk (ref_clk),
    .rst     (rst),
    .inc     (inc0),
    .clr     (rd_counts),
    .count_q (count0),
    .sat_hit (sat0)
  );

  sat_clear_counter #(
    .WIDTH   (CW)
  ) u_counter1 (
    .ref_clk (ref_clk),
    .rst     (rst),
    .inc     (inc1),
    .clr     (rd_counts),
    .count_q (count1),
    .sat_hit (sat1)
  );

  // Interrupt status, enable and clear.
  always_comb begin
    irq_enable_d = irq_enable_q;
    if (wr_irq_en) begin
      irq_enable_d = reg_wr_data[IW-1:0];
    end
    irq_status_d = irq_status_q;
    if (wr_irq_clr) begin
      irq_status_d = irq_status_d & ~reg_wr_data[IW-1:0];
    end
    // A new event in the clearing cycle survives the clear.
    irq_status_d[serdes_test_pkg::IRQ_SYNC_BIT] =
      irq_status_d[serdes_test_pkg::IRQ_SYNC_BIT] || (|(sync_set & ~sync_q));
    irq_status_d[serdes_test_pkg::IRQ_SAT0_BIT] =
      irq_status_d[serdes_test_pkg::IRQ_SAT0_BIT] || sat0;
    irq_status_d[serdes_test_pkg::IRQ_SAT1_BIT] =
      irq_status_d[serdes_test_pkg::IRQ_SAT1_BIT] || sat1;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq_enable_q <= serdes_test_pkg::IRQ_RESET;
      irq_status_q <= serdes_test_pkg::IRQ_RESET;
    end else begin
      irq_enable_q <= irq_enable_d;
      irq_status_q <= irq_status_d;
    end
  end

  // Read data, answered in the cycle after the strobe.
  always_comb begin
    rd_data_d = '0;
    if (reg_rd) begin
      case (reg_addr)
        serdes_test_pkg::TEST_CTRL_OFFSET: begin
          rd_data_d[serdes_test_pkg::ENABLE_LSB +: NL] = enable_q;
          rd_data_d[serdes_test_pkg::INVERT_BIT]       = invert_q;
        end
        serdes_test_pkg::SYNC_STATUS_OFFSET: begin
          rd_data_d[NL-1:0] = sync_q;
        end
        serdes_test_pkg::CNT_CFG_OFFSET: begin
          rd_data_d[serdes_test_pkg::CFG_USED_W-1:0] = cfg_q;
        end
        serdes_test_pkg::CNT01_OFFSET: begin
          rd_data_d[0 +: CW]                        = count0;
          rd_data_d[serdes_test_pkg::CNT1_LSB +: CW] = count1;
        end
        serdes_test_pkg::IRQ_STATUS_OFFSET: begin
          rd_data_d[IW-1:0] = irq_status_q;
        end
        serdes_test_pkg::IRQ_ENABLE_OFFSET: begin
          rd_data_d[IW-1:0] = irq_enable_q;
        end
        default: begin
          rd_data_d = '0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rd_data_q <= '0;
    end else begin
      rd_data_q <= rd_data_d;
    end
  end

  // Outputs.
  always_comb begin
    reg_rd_data          = rd_data_q;
    lane_participate     = participate_q;
    tx_resync            = tx_resync_q;
    rx_resync            = rx_resync_q;
    invert_tx_stream     = invert_q;
    extra_counter_select = cfg_q[serdes_test_pkg::CFG_USED_W-1:2*SW];
    irq                  = |(irq_status_q & irq_enable_q);
  end

endmodule

// ---- serdes_test_sync_error_count_checker.sv ----
// Port-level assertions for the serial-lane sync status and error counter block.
// Assumes one clock ref_clk with synchronous active-high rst; bound to the block below.
`timescale 1ns/1ps
module serdes_test_sync_error_count_checker #(
  parameter int LANES = serdes_test_pkg::LANES
) (
  // Clock and reset.
  input wire logic                               ref_clk,
  input wire logic                               rst,
  // Register port.
  input wire logic [serdes_test_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [serdes_test_pkg::DATA_W-1:0] reg_wr_data,
  input wire logic                               reg_wr,
  input wire logic                               reg_rd,
  input wire logic [serdes_test_pkg::DATA_W-1:0] reg_rd_data,
  // Switch mode.
  input wire logic                               test_mode_active,
  input wire logic                               test_mode_sync_needed,
  // Lanes.
  input wire logic [3*LANES-1:0]                 lane_sync_done,
  input wire logic [3*LANES-1:0]                 lane_error,
  input wire logic [3*LANES-1:0]                 lane_participate,
  // Control outputs.
  input wire logic                               tx_resync,
  input wire logic                               rx_resync,
  input wire logic                               invert_tx_stream,
  input wire logic [19:0]                        extra_counter_select,
  input wire logic                               irq
);
  logic        ctrl_wr;
  logic        cfg_wr;
  logic        rx_req;
  logic        tx_req;
  logic [19:0] wr_sel;
  assign ctrl_wr = reg_wr && (reg_addr == serdes_test_pkg::TEST_CTRL_OFFSET);
  assign cfg_wr = reg_wr && (reg_addr == serdes_test_pkg::CNT_CFG_OFFSET);
  assign rx_req = ctrl_wr && test_mode_active && test_mode_sync_needed && reg_wr_data[26];
  assign tx_req = ctrl_wr && test_mode_active && test_mode_sync_needed && reg_wr_data[25];
  assign wr_sel = reg_wr_data[29:10];

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  sequence s_rd(logic [7:0] a);
    reg_rd && (reg_addr == a);
  endsequence
  sequence s_quiet_clear;
    reg_rd && (reg_addr == serdes_test_pkg::CNT01_OFFSET) && !test_mode_active
      ##1 !test_mode_active;
  endsequence

  a_rd_idle_zero: assert property (!$past(reg_rd) |-> reg_rd_data == '0)
    else $error("read data not zero outside the answer cycle");
  a_cfg_top_zero: assert property (s_rd(serdes_test_pkg::CNT_CFG_OFFSET) |=>
    reg_rd_data[31:30] == 2'h0) else $error("config top bits not zero");
  a_sync_top_zero: assert property (s_rd(serdes_test_pkg::SYNC_STATUS_OFFSET) |=>
    reg_rd_data[31:24] == 8'h00) else $error("sync status top byte not zero");
  a_resync_read_zero: assert property (s_rd(serdes_test_pkg::TEST_CTRL_OFFSET) |=>
    reg_rd_data[31:25] == 7'h00) else $error("resync bits not read as zero");
  a_extra_sel_follow: assert property ($past(cfg_wr, 2) && !$past(cfg_wr) |->
    extra_counter_select == $past(wr_sel, 2)) else $error("extra selectors not written");
  a_part_mode_off: assert property (!$past(test_mode_active) |-> lane_participate == '0)
    else $error("lanes participate outside test mode");
  a_rx_resync_pulse: assert property (rx_resync == $past(rx_req))
    else $error("receive resync pulse wrong");
  a_tx_resync_pulse: assert property (tx_resync == $past(tx_req))
    else $error("transmit resync pulse wrong");
  a_cnt_read_clears: assert property (s_quiet_clear ##1
    s_rd(serdes_test_pkg::CNT01_OFFSET) |=> reg_rd_data == '0) else $error("count not cleared");
endmodule

bind serdes_test_sync_error_count serdes_test_sync_error_count_checker #(.LANES(LANES)) u_chk (
  .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rd_data(reg_rd_data),
  .test_mode_active(test_mode_active), .test_mode_sync_needed(test_mode_sync_needed),
  .lane_sync_done(lane_sync_done), .lane_error(lane_error),
  .lane_participate(lane_participate), .tx_resync(tx_resync), .rx_resync(rx_resync),
  .invert_tx_stream(invert_tx_stream), .extra_counter_select(extra_counter_select), .irq(irq));

// ---- tb_serdes_test_sync_error_count.sv ----
// Self-checking bench for the serial-lane sync status and error counter block.
// Assumes a 40 MHz ref_clk and the register offsets of serdes_test_pkg.
`timescale 1ns/1ps
module tb_serdes_test_sync_error_count;
  localparam logic [7:0] CTRL = serdes_test_pkg::TEST_CTRL_OFFSET;
  localparam logic [7:0] SYNC = serdes_test_pkg::SYNC_STATUS_OFFSET;
  localparam logic [7:0] CFG  = serdes_test_pkg::CNT_CFG_OFFSET;
  localparam logic [7:0] CNT  = serdes_test_pkg::CNT01_OFFSET;
  localparam logic [7:0] IST  = serdes_test_pkg::IRQ_STATUS_OFFSET;
  localparam logic [7:0] IEN  = serdes_test_pkg::IRQ_ENABLE_OFFSET;
  localparam logic [7:0] ICL  = serdes_test_pkg::IRQ_CLEAR_OFFSET;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wr_data = 32'h0000_0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rd_data;
  logic        test_mode_active = 1'b0;
  logic        test_mode_sync_needed = 1'b0;
  logic [23:0] lane_sync_done = 24'h00_0000;
  logic [23:0] lane_error = 24'h00_0000;
  logic [23:0] lane_participate;
  logic        tx_resync;
  logic        rx_resync;
  logic        invert_tx_stream;
  logic [19:0] extra_counter_select;
  logic        irq;
  int          n_fail = 0;
  int          comparisons = 0;

  always #12.5 ref_clk = ~ref_clk;

  serdes_test_sync_error_count u_serdes_test_sync_error_count (
    .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rd_data(reg_rd_data),
    .test_mode_active(test_mode_active), .test_mode_sync_needed(test_mode_sync_needed),
    .lane_sync_done(lane_sync_done), .lane_error(lane_error),
    .lane_participate(lane_participate), .tx_resync(tx_resync), .rx_resync(rx_resync),
    .invert_tx_stream(invert_tx_stream), .extra_counter_select(extra_counter_select), .irq(irq));

  task automatic print_verdict();
    if (n_fail == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] act, input logic [31:0] exp);
    comparisons++;
    if (act !== exp) begin
      n_fail++;
      $display("BAD %0t got %h expected %h", $time, act, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wr_data <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(negedge ref_clk);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    chk(reg_rd_data, exp);
  endtask

  // Each high cycle of the mask is one error event on those lanes.
  task automatic pulse(input logic [23:0] m, input int n);
    @(posedge ref_clk);
    lane_error <= m;
    repeat (n) @(posedge ref_clk);
    lane_error <= 24'h00_0000;
  endtask

  task automatic set_mode(input logic act, input logic need);
    @(posedge ref_clk);
    test_mode_active <= act;
    test_mode_sync_needed <= need;
  endtask

  task automatic t_reset();
    rchk(SYNC, 32'h0000_0000);
    rchk(CFG, 32'h0000_0000);
    rchk(CNT, 32'h0000_0000);
    rchk(CTRL, 32'h00ff_ffff);
    rchk(8'h10, 32'h0000_0000);
    wr(CFG, 32'hffff_ffff);
    rchk(CFG, 32'h3fff_ffff);
    chk({12'h000, extra_counter_select}, 32'h000f_ffff);
  endtask

  task automatic t_sync_irq();
    wr(CTRL, 32'h00ff_fdff);
    set_mode(1'b1, 1'b0);
    lane_sync_done <= 24'h81_4301;
    @(posedge ref_clk);
    lane_sync_done <= 24'h00_0000;
    rchk(SYNC, 32'h0081_4101);
    chk({8'h00, lane_participate}, 32'h00ff_fdff);
    chk({31'h0000_0000, irq}, 32'h0000_0000);
    rchk(IST, 32'h0000_0001);
    wr(IEN, 32'h0000_0001);
    chk({31'h0000_0000, irq}, 32'h0000_0001);
    wr(SYNC, 32'h0000_0000);
    rchk(SYNC, 32'h0081_4101);
    wr(SYNC, 32'h0000_0101);
    rchk(SYNC, 32'h0081_4000);
    wr(ICL, 32'h0000_0001);
    chk({31'h0000_0000, irq}, 32'h0000_0000);
    rchk(IST, 32'h0000_0000);
    wr(SYNC, 32'hffff_ffff);
    wr(CTRL, 32'h00ff_ffff);
  endtask

  // Counter 0 watches lane 5 and counter 1 lane 2 of port p; p 3 selects nothing.
  task automatic t_select();
    logic [23:0] b0;
    logic [23:0] b1;
    for (int p = 0; p < 4; p++) begin
      b0 = 24'h00_0001 << (p * 8 + 5);
      b1 = 24'h00_0001 << (p * 8 + 2);
      wr(CFG, 32'((p << 8) | (p << 3) | 32'h0000_0045));
      pulse(~(b0 | b1), 2);
      pulse(b0, 3);
      pulse(b1, 1);
      rchk(CNT, (p < 3) ? 32'h0001_0003 : 32'h0000_0000);
      rchk(CNT, 32'h0000_0000);
    end
  endtask

  task automatic t_mode_off();
    wr(CFG, 32'h0000_0000);
    set_mode(1'b0, 1'b0);
    rchk(CNT, 32'h0000_0000);
    rchk(CNT, 32'h0000_0000);
    pulse(24'hff_ffff, 4);
    rchk(CNT, 32'h0000_0000);
    chk({8'h00, lane_participate}, 32'h0000_0000);
  endtask

  task automatic t_collide_sat();
    set_mode(1'b1, 1'b0);
    pulse(24'h00_0001, 2);
    @(posedge ref_clk);
    lane_error <= 24'h00_0001;
    reg_rd <= 1'b1;
    reg_addr <= CNT;
    @(posedge ref_clk);
    lane_error <= 24'h00_0000;
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    chk(reg_rd_data, 32'h0002_0002);
    rchk(CNT, 32'h0001_0001);
    pulse(24'h00_0001, 65537);
    rchk(IST, 32'h0000_0006);
    wr(IEN, 32'h0000_0006);
    chk({31'h0000_0000, irq}, 32'h0000_0001);
    rchk(CNT, 32'hffff_ffff);
  endtask

  task automatic t_resync();
    set_mode(1'b1, 1'b1);
    wr(CTRL, 32'h04ff_ffff);
    chk({30'h0000_0000, tx_resync, rx_resync}, 32'h0000_0001);
    rchk(CTRL, 32'h00ff_ffff);
    wr(CTRL, 32'h02ff_ffff);
    chk({30'h0000_0000, tx_resync, rx_resync}, 32'h0000_0002);
    set_mode(1'b1, 1'b0);
    wr(CTRL, 32'h06ff_ffff);
    chk({30'h0000_0000, tx_resync, rx_resync}, 32'h0000_0000);
    chk({31'h0000_0000, invert_tx_stream}, 32'h0000_0000);
    wr(CTRL, 32'h01ff_ffff);
    chk({31'h0000_0000, invert_tx_stream}, 32'h0000_0001);
    rchk(CTRL, 32'h01ff_ffff);
  endtask

  initial begin
    repeat (90000) @(posedge ref_clk);
    n_fail++;
    print_verdict();
  end

  initial begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset();
    t_sync_irq();
    t_select();
    t_mode_off();
    t_collide_sat();
    t_resync();
    print_verdict();
  end
endmodule
